/* common/gfx_port_pkg.sv */
// Constants and types for the graphics port format control block.
// Notes on behaviour
// - The cursor read index stays on each entry for a red, green and blue read, then steps by one.
// - The read index register keeps the entry in bits 1:0, resets to zero, and bits 7:2 are reserved zero.
// - The read index picks the cursor palette entry returned by reads of the cursor colour data port.
// - The cursor palette holds four 24-bit entries: border, cursor colour one, two and three.
// - With DAC off and clock off both set, the DAC output is disabled and the internal clock is held high.
// - The port format field sets packing: 24-bit 1:1, 16-bit, four 8-bit at 4:1, eight 4-bit at 8:1.
// - On the wide port the shift clock runs at pixel, pixel/2 or pixel, pixel/4, pixel/8; on the legacy port at pixel rate.
// - Port select codes 00 and 11 pick the legacy port, 10 the wide port, 01 the wide port only with the select pin high.
// - Wide-port pixels index the palette unless true colour is set; legacy pixels always index it.
// - The colour format bit reads wide-port pixels as 5:5:5 when clear and 5:6:5 when set.
// - For 16-bit data the rate bit gives two pixels a word at 2:1 when clear and one pixel at 1:1 when set.
// - For 5:5:5 data the tag enable bit makes the top wide-port bit the per-pixel video selector.
// - At 1:1 the pixel selector bit takes the pixel from the low half-word when clear, high when set.
// - The shift clock disable bit stops the shift clock output when set.
// - Port select 00 keeps the legacy input, 01 enables the wide port, 10 forces it, 11 drives the serial port out.
package gfx_port_pkg;

    localparam logic [4:0] ADDR_CURSOR_WR_INDEX = 5'h04;
    localparam logic [4:0] ADDR_CURSOR_DATA     = 5'h05;
    localparam logic [4:0] ADDR_ANALOG_SETUP    = 5'h06;
    localparam logic [4:0] ADDR_CURSOR_RD_INDEX = 5'h07;
    localparam logic [4:0] ADDR_GFX_FORMAT      = 5'h08;
    localparam logic [4:0] ADDR_CURSOR_SETUP    = 5'h09;

    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] GFC_RW_MASK = 8'h7F;
    localparam logic [1:0] INDEX_RESET = 2'h0;
    localparam logic [1:0] INDEX_STEP  = 2'h1;

    localparam int ASC_CLOCK_OFF = 6;
    localparam int ASC_DAC_OFF   = 0;
    localparam int GFC_FMT_HI    = 6;
    localparam int GFC_FMT_LO    = 5;
    localparam int GFC_TRUE_COL  = 4;
    localparam int GFC_COL_FMT   = 3;
    localparam int GFC_MUX_RATE  = 2;
    localparam int GFC_TAG_EN    = 1;
    localparam int GFC_PIX_SEL   = 0;
    localparam int CSC_SCLK_DIS  = 7;
    localparam int CSC_DPS_HI    = 6;
    localparam int CSC_DPS_LO    = 5;
    localparam int WIDE_TOP_BIT  = 31;

    localparam logic [1:0] FMT_RGB888 = 2'h0;
    localparam logic [1:0] FMT_16BIT  = 2'h1;
    localparam logic [1:0] FMT_QUAD8  = 2'h2;
    localparam logic [1:0] FMT_OCT4   = 2'h3;

    localparam logic [1:0] DPS_LEGACY     = 2'h0;
    localparam logic [1:0] DPS_BY_PIN     = 2'h1;
    localparam logic [1:0] DPS_WIDE       = 2'h2;
    localparam logic [1:0] DPS_SERIAL_OUT = 2'h3;

    localparam logic [2:0] MASK_DIV1 = 3'h0;
    localparam logic [2:0] MASK_DIV2 = 3'h1;
    localparam logic [2:0] MASK_DIV4 = 3'h3;
    localparam logic [2:0] MASK_DIV8 = 3'h7;

    typedef enum logic [1:0] {
        COMP_RED,
        COMP_GREEN,
        COMP_BLUE
    } colour_comp_e;

    typedef struct packed {
        logic [1:0] port_format;
        logic       true_colour;
        logic       colour_format;
        logic       mux_rate;
        logic       tag_enable;
        logic       pixel_sel;
        logic       sclk_disable;
        logic       wide_active;
        logic       clock_hold;
    } pixel_cfg_s;

    typedef struct packed {
        logic [23:0] pixel;
        logic        palette_bypass;
        logic        video_select;
        logic        rgb565;
    } pixel_out_s;

endpackage

/* verilog/cursor_palette.sv */
// Four-entry cursor colour palette with auto-stepping write and read indices.
`timescale 1ns/100ps
module cursor_palette (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      wr_index_load,
    input  wire logic                      rd_index_load,
    input  wire logic [1:0]                index_value,
    input  wire logic                      data_wr,
    input  wire logic                      data_rd,
    input  wire logic [7:0]                wr_data,
    output logic [7:0]                     rd_byte,
    output logic [1:0]                     rd_index,
    output gfx_port_pkg::colour_comp_e     rd_comp
);
    import gfx_port_pkg::*;

    logic [23:0]  entry_mem [4];
    logic [1:0]   wr_index_reg, wr_index_next;
    colour_comp_e wr_comp_reg, wr_comp_next;
    logic [1:0]   rd_index_reg, rd_index_next;
    colour_comp_e rd_comp_reg, rd_comp_next;

    assign rd_index = rd_index_reg;
    assign rd_comp  = rd_comp_reg;

    // Red sits in the top byte of each entry.
    always_comb begin
        case (rd_comp_reg)
            COMP_RED:   rd_byte = entry_mem[rd_index_reg][23:16];
            COMP_GREEN: rd_byte = entry_mem[rd_index_reg][15:8];
            default:    rd_byte = entry_mem[rd_index_reg][7:0];
        endcase
    end

    always_comb begin
        wr_index_next = wr_index_reg;
        wr_comp_next  = wr_comp_reg;
        rd_index_next = rd_index_reg;
        rd_comp_next  = rd_comp_reg;
        if (wr_index_load) begin
            wr_index_next = index_value;
            wr_comp_next  = COMP_RED;
        end else if (data_wr) begin
            if (wr_comp_reg == COMP_BLUE) begin
                wr_comp_next  = COMP_RED;
                wr_index_next = wr_index_reg + INDEX_STEP;
            end else begin
                wr_comp_next = colour_comp_e'(wr_comp_reg + 2'h1);
            end
        end
        if (rd_index_load) begin
            rd_index_next = index_value;
            rd_comp_next  = COMP_RED;
        end else if (data_rd) begin
            if (rd_comp_reg == COMP_BLUE) begin
                rd_comp_next  = COMP_RED;
                rd_index_next = rd_index_reg + INDEX_STEP;
            end else begin
                rd_comp_next = colour_comp_e'(rd_comp_reg + 2'h1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_index_reg <= INDEX_RESET;
            wr_comp_reg  <= COMP_RED;
            rd_index_reg <= INDEX_RESET;
            rd_comp_reg  <= COMP_RED;
        end else begin
            wr_index_reg <= wr_index_next;
            wr_comp_reg  <= wr_comp_next;
            rd_index_reg <= rd_index_next;
            rd_comp_reg  <= rd_comp_next;
        end
    end

    // Border, cursor colour one, two and three in index order.
    always_ff @(posedge sys_clk) begin
        if (data_wr) begin
            case (wr_comp_reg)
                COMP_RED:   entry_mem[wr_index_reg][23:16] <= wr_data;
                COMP_GREEN: entry_mem[wr_index_reg][15:8]  <= wr_data;
                default:    entry_mem[wr_index_reg][7:0]   <= wr_data;
            endcase
        end
    end

    a_read_step: assert property (@(posedge sys_clk) disable iff (rst)
        data_rd && !rd_index_load && rd_comp_reg == COMP_BLUE
        |=> rd_index_reg == 2'($past(rd_index_reg) + INDEX_STEP)
            && rd_comp_reg == COMP_RED)
        else $error("Read index did not step after blue.");

    a_read_hold: assert property (@(posedge sys_clk) disable iff (rst)
        data_rd && !rd_index_load && rd_comp_reg != COMP_BLUE
        |=> $stable(rd_index_reg))
        else $error("Read index moved before blue.");

endmodule

/* verilog/shift_clock_gen.sv */
// Shift and load clock strobes on the pixel clock.
`timescale 1ns/100ps
module shift_clock_gen (
    input  wire logic                      pixel_clock,
    input  wire logic                      rst,
    input  gfx_port_pkg::pixel_cfg_s       cfg,
    output logic                           shift_clock,
    output logic                           load_clock,
    output logic [2:0]                     phase
);
    import gfx_port_pkg::*;

    logic [2:0] phase_reg, phase_next;
    logic       shift_reg, shift_next;
    logic       load_reg, load_next;
    logic [2:0] shift_mask;
    logic [2:0] load_mask;

    assign shift_clock = shift_reg;
    assign load_clock  = load_reg;
    assign phase       = phase_reg;

    always_comb begin
        case (cfg.port_format)
            FMT_RGB888: load_mask = MASK_DIV1;
            FMT_16BIT:  load_mask = cfg.mux_rate ? MASK_DIV1 : MASK_DIV2;
            FMT_QUAD8:  load_mask = MASK_DIV4;
            default:    load_mask = MASK_DIV8;
        endcase
        shift_mask = cfg.wide_active ? load_mask : MASK_DIV1;
        phase_next = phase_reg + 3'h1;
        load_next  = (phase_reg & load_mask) == 3'h0;
        shift_next = (phase_reg & shift_mask) == 3'h0;
        if (cfg.clock_hold) begin
            shift_next = 1'b1;
            load_next  = 1'b1;
        end else if (cfg.sclk_disable) begin
            shift_next = 1'b0;
        end
    end

    always_ff @(posedge pixel_clock or posedge rst) begin
        if (rst) begin
            phase_reg <= 3'h0;
            shift_reg <= 1'b0;
            load_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            shift_reg <= shift_next;
            load_reg  <= load_next;
        end
    end

endmodule

/* verilog/gfx_port_top.sv */
// Graphics port format control: registers, port choice and pixel path.
`timescale 1ns/100ps
module gfx_port_top (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      pixel_clock,
    input  wire logic [4:0]                reg_addr,
    input  wire logic [7:0]                reg_wr_data,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rd_data,
    input  wire logic                      port_select_input,
    input  wire logic [7:0]                legacy_port,
    input  wire logic [31:0]               wide_graphics_port,
    output logic                           shift_clock,
    output logic                           load_clock,
    output logic                           wide_port_active,
    output logic                           serial_port_drive,
    output logic                           dac_disable,
    output gfx_port_pkg::pixel_out_s       pixel_out
);
    import gfx_port_pkg::*;

    // ==========================================================
    // Select pin synchroniser.
    logic gps_meta_reg;
    logic gps_sync_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gps_meta_reg <= 1'b0;
            gps_sync_reg <= 1'b0;
        end else begin
            gps_meta_reg <= port_select_input;
            gps_sync_reg <= gps_meta_reg;
        end
    end

    // ==========================================================
    // Register file.
    logic [7:0]   asc_reg, asc_next;
    logic [7:0]   gfc_reg, gfc_next;
    logic [7:0]   csc_reg, csc_next;
    logic [7:0]   rd_data_reg, rd_data_next;
    logic         wide_reg, wide_next;
    logic         serial_reg, serial_next;
    logic         dac_dis_reg, dac_dis_next;
    pixel_cfg_s   cfg_reg, cfg_next;
    logic         wr_index_load;
    logic         rd_index_load;
    logic         data_wr;
    logic         data_rd;
    logic [7:0]   pal_byte;
    logic [1:0]   rd_index;
    colour_comp_e rd_comp;
    logic [1:0]   data_port_select;

    assign wr_index_load = reg_wr && reg_addr == ADDR_CURSOR_WR_INDEX;
    assign rd_index_load = reg_wr && reg_addr == ADDR_CURSOR_RD_INDEX;
    assign data_wr       = reg_wr && reg_addr == ADDR_CURSOR_DATA;
    assign data_rd       = reg_rd && reg_addr == ADDR_CURSOR_DATA;
    assign data_port_select           = csc_reg[CSC_DPS_HI:CSC_DPS_LO];

    cursor_palette u_palette (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .wr_index_load (wr_index_load),
        .rd_index_load (rd_index_load),
        .index_value   (reg_wr_data[1:0]),
        .data_wr       (data_wr),
        .data_rd       (data_rd),
        .wr_data       (reg_wr_data),
        .rd_byte       (pal_byte),
        .rd_index      (rd_index),
        .rd_comp       (rd_comp)
    );

    always_comb begin
        asc_next = asc_reg;
        gfc_next = gfc_reg;
        csc_next = csc_reg;
        if (reg_wr) begin
            if (reg_addr == ADDR_ANALOG_SETUP) begin
                asc_next = reg_wr_data;
            end else if (reg_addr == ADDR_GFX_FORMAT) begin
                gfc_next = reg_wr_data & GFC_RW_MASK;
            end else if (reg_addr == ADDR_CURSOR_SETUP) begin
                csc_next = reg_wr_data;
            end
        end
    end

    always_comb begin
        rd_data_next = rd_data_reg;
        if (reg_rd) begin
            if (reg_addr == ADDR_CURSOR_DATA) begin
                rd_data_next = pal_byte;
            end else if (reg_addr == ADDR_ANALOG_SETUP) begin
                rd_data_next = asc_reg;
            end else if (reg_addr == ADDR_CURSOR_RD_INDEX) begin
                rd_data_next = {6'h00, rd_index};
            end else if (reg_addr == ADDR_GFX_FORMAT) begin
                rd_data_next = gfc_reg;
            end else if (reg_addr == ADDR_CURSOR_SETUP) begin
                rd_data_next = csc_reg;
            end else begin
                rd_data_next = REG_RESET;
            end
        end
    end

    always_comb begin
        case (data_port_select)
            DPS_BY_PIN: wide_next = gps_sync_reg;
            DPS_WIDE:   wide_next = 1'b1;
            default:    wide_next = 1'b0;
        endcase
        serial_next  = data_port_select == DPS_SERIAL_OUT;
        dac_dis_next = asc_reg[ASC_DAC_OFF] && asc_reg[ASC_CLOCK_OFF];
        cfg_next.port_format   = gfc_reg[GFC_FMT_HI:GFC_FMT_LO];
        cfg_next.true_colour   = gfc_reg[GFC_TRUE_COL];
        cfg_next.colour_format = gfc_reg[GFC_COL_FMT];
        cfg_next.mux_rate      = gfc_reg[GFC_MUX_RATE];
        cfg_next.tag_enable    = gfc_reg[GFC_TAG_EN];
        cfg_next.pixel_sel     = gfc_reg[GFC_PIX_SEL];
        cfg_next.sclk_disable  = csc_reg[CSC_SCLK_DIS];
        cfg_next.wide_active   = wide_next;
        cfg_next.clock_hold    = dac_dis_next;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            asc_reg     <= REG_RESET;
            gfc_reg     <= REG_RESET;
            csc_reg     <= REG_RESET;
            rd_data_reg <= REG_RESET;
            wide_reg    <= 1'b0;
            serial_reg  <= 1'b0;
            dac_dis_reg <= 1'b0;
            cfg_reg     <= '0;
        end else begin
            asc_reg     <= asc_next;
            gfc_reg     <= gfc_next;
            csc_reg     <= csc_next;
            rd_data_reg <= rd_data_next;
            wide_reg    <= wide_next;
            serial_reg  <= serial_next;
            dac_dis_reg <= dac_dis_next;
            cfg_reg     <= cfg_next;
        end
    end

    assign reg_rd_data       = rd_data_reg;
    assign wide_port_active  = wide_reg;
    assign serial_port_drive = serial_reg;
    assign dac_disable       = dac_dis_reg;

    // ==========================================================
    // Configuration crossing into the pixel clock domain.
    pixel_cfg_s cfg_meta_reg;
    pixel_cfg_s cfg_pix_reg;

    always_ff @(posedge pixel_clock or posedge rst) begin
        if (rst) begin
            cfg_meta_reg <= '0;
            cfg_pix_reg  <= '0;
        end else begin
            cfg_meta_reg <= cfg_reg;
            cfg_pix_reg  <= cfg_meta_reg;
        end
    end

    logic [2:0] phase;

    shift_clock_gen u_shift (
        .pixel_clock (pixel_clock),
        .rst         (rst),
        .cfg         (cfg_pix_reg),
        .shift_clock (shift_clock),
        .load_clock  (load_clock),
        .phase       (phase)
    );

    // ==========================================================
    // Pixel selection.
    pixel_out_s  pix_reg, pix_next;
    logic        high_half;
    logic [15:0] half_word;
    logic [7:0]  quad_byte;
    logic [3:0]  oct_nib;

    always_comb begin
        high_half = cfg_pix_reg.mux_rate ? cfg_pix_reg.pixel_sel
                                         : phase[0];
        half_word = high_half ? wide_graphics_port[31:16]
                              : wide_graphics_port[15:0];
        quad_byte = wide_graphics_port[8*phase[1:0] +: 8];
        oct_nib   = wide_graphics_port[4*phase +: 4];
        pix_next.palette_bypass = 1'b0;
        pix_next.video_select   = 1'b0;
        pix_next.rgb565         = cfg_pix_reg.colour_format;
        pix_next.pixel          = {16'h0000, legacy_port};
        if (cfg_pix_reg.wide_active) begin
            pix_next.palette_bypass = cfg_pix_reg.true_colour;
            case (cfg_pix_reg.port_format)
                FMT_RGB888: pix_next.pixel = wide_graphics_port[23:0];
                FMT_16BIT: begin
                    pix_next.pixel = {8'h00, half_word};
                    if (!cfg_pix_reg.colour_format
                        && cfg_pix_reg.tag_enable) begin
                        pix_next.video_select =
                            wide_graphics_port[WIDE_TOP_BIT];
                    end
                end
                FMT_QUAD8: pix_next.pixel = {16'h0000, quad_byte};
                default:   pix_next.pixel = {20'h00000, oct_nib};
            endcase
        end
    end

    always_ff @(posedge pixel_clock or posedge rst) begin
        if (rst) begin
            pix_reg <= '0;
        end else begin
            pix_reg <= pix_next;
        end
    end

    assign pixel_out = pix_reg;

    // ==========================================================
    // Checks.
    a_port_map: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 wide_port_active == ($past(data_port_select) == DPS_WIDE
            || ($past(data_port_select) == DPS_BY_PIN && $past(gps_sync_reg))))
        else $error("Wide port flag does not follow port select.");

    a_serial_drive: assert property (@(posedge sys_clk) disable iff (rst)
        data_port_select == DPS_SERIAL_OUT |=> serial_port_drive && !wide_port_active)
        else $error("Serial output code did not drive the port.");

    a_dac_off: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 dac_disable == ($past(asc_reg[ASC_DAC_OFF])
            && $past(asc_reg[ASC_CLOCK_OFF])))
        else $error("DAC disable does not match both off controls.");

    a_index_read: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == ADDR_CURSOR_RD_INDEX
        |=> reg_rd_data[7:2] == 6'h00 && reg_rd_data[1:0] == $past(rd_index))
        else $error("Read index register read back wrong.");

    a_index_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        data_rd && !rd_index_load && rd_comp == COMP_BLUE && rd_index == 2'h3
        |=> rd_index == INDEX_RESET)
        else $error("Read index did not wrap to zero.");

    a_sclk_stop: assert property (@(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.sclk_disable && !cfg_pix_reg.clock_hold |=> !shift_clock)
        else $error("Shift clock ran while disabled.");

    a_clock_hold: assert property (
        @(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.clock_hold |=> shift_clock && load_clock)
        else $error("Clocks not held high while powered down.");

    a_quarter_rate: assert property (
        @(posedge pixel_clock) disable iff (rst)
        shift_clock && cfg_pix_reg.wide_active && !cfg_pix_reg.sclk_disable
        && !cfg_pix_reg.clock_hold && cfg_pix_reg.port_format == FMT_QUAD8
        && $stable(cfg_pix_reg) && cfg_pix_reg == $past(cfg_pix_reg, 2)
        && cfg_pix_reg == $past(cfg_pix_reg, 3)
        && cfg_pix_reg == $past(cfg_pix_reg, 4)
        && cfg_pix_reg == $past(cfg_pix_reg, 5)
        |-> !$past(shift_clock) && !$past(shift_clock, 2)
            && !$past(shift_clock, 3) && $past(shift_clock, 4))
        else $error("Shift clock not at a quarter of pixel rate.");

    a_legacy_palette: assert property (
        @(posedge pixel_clock) disable iff (rst)
        !cfg_pix_reg.wide_active |=> !pixel_out.palette_bypass
            && pixel_out.pixel == {16'h0000, $past(legacy_port)})
        else $error("Legacy pixel bypassed the palette.");

    a_legacy_rate: assert property (
        @(posedge pixel_clock) disable iff (rst)
        !cfg_pix_reg.wide_active && !cfg_pix_reg.sclk_disable |=> shift_clock)
        else $error("Shift clock not at pixel rate on the legacy port.");

    a_wide_bypass: assert property (
        @(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.wide_active
        |=> pixel_out.palette_bypass == $past(cfg_pix_reg.true_colour))
        else $error("Wide pixel bypass does not follow true colour.");

    a_tag_select: assert property (
        @(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.wide_active && cfg_pix_reg.port_format == FMT_16BIT
        && !cfg_pix_reg.colour_format && cfg_pix_reg.tag_enable
        |=> pixel_out.video_select == $past(wide_graphics_port[WIDE_TOP_BIT]))
        else $error("Tagged pixel lost its video selector.");

    a_half_select: assert property (
        @(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.wide_active && cfg_pix_reg.port_format == FMT_16BIT
        && cfg_pix_reg.mux_rate
        |=> pixel_out.pixel[15:0] == ($past(cfg_pix_reg.pixel_sel)
            ? $past(wide_graphics_port[31:16])
            : $past(wide_graphics_port[15:0])))
        else $error("Pixel selector took the wrong half-word.");

    a_rgb888_pixel: assert property (
        @(posedge pixel_clock) disable iff (rst)
        cfg_pix_reg.wide_active && cfg_pix_reg.port_format == FMT_RGB888
        |=> pixel_out.pixel == $past(wide_graphics_port[23:0]))
        else $error("Packed 24-bit pixel not passed through.");

    a_legacy_code: assert property (@(posedge sys_clk) disable iff (rst)
        data_port_select == DPS_LEGACY |=> !wide_port_active && !serial_port_drive)
        else $error("Legacy code did not select the legacy port.");

endmodule

/* verif/gfx_source_model.sv */
// Pixel source model that feeds both graphics ports on the pixel clock.
`timescale 1ns/100ps
module gfx_source_model (
    input  wire logic        pixel_clock,
    input  wire logic        rst,
    output logic [7:0]       legacy_port,
    output logic [31:0]      wide_graphics_port
);
    // ==========================================================
    // Pixel words
    // A fresh word every pixel cycle, launched on the falling edge.
    initial begin
        legacy_port        = 8'h00;
        wide_graphics_port = 32'h00000000;
    end
    always @(negedge pixel_clock) begin
        legacy_port        <= rst ? 8'h00 : 8'($urandom);
        wide_graphics_port <= rst ? 32'h00000000 : $urandom;
    end
endmodule

/* verif/graphics_port_format_control_tb.sv */
// Self-checking bench for the graphics port format control block.
`timescale 1ns/100ps
module graphics_port_format_control_tb;
    import gfx_port_pkg::*;
    // ==========================================================
    // Signals
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    logic             pixel_clock = 1'b0;
    logic [4:0]       reg_addr = 5'h00;
    logic [7:0]       reg_wr_data = 8'h00;
    logic             reg_wr = 1'b0;
    logic             reg_rd = 1'b0;
    logic             port_select_input = 1'b0;
    logic [7:0]       reg_rd_data, legacy_port, got;
    logic [31:0]      wide_graphics_port;
    logic             shift_clock, load_clock, wide_port_active;
    logic             serial_port_drive, dac_disable, tc, cf;
    pixel_out_s       pixel_out;
    int               miscompares = 0;
    int               compares = 0;
    int               pal [4][3];
    int               ratio [8] = '{1, 1, 2, 1, 4, 4, 8, 8};
    int               idx, cnt;

    always #10 sys_clk = ~sys_clk;
    initial #7 forever #62.5 pixel_clock = ~pixel_clock;

    gfx_port_top dut_u (.sys_clk, .rst, .pixel_clock, .reg_addr,
        .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .port_select_input,
        .legacy_port, .wide_graphics_port, .shift_clock, .load_clock,
        .wide_port_active, .serial_port_drive, .dac_disable, .pixel_out);
    gfx_source_model src_u (.pixel_clock, .rst, .legacy_port,
        .wide_graphics_port);

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr      = 1'b1;
        @(negedge sys_clk);
        reg_wr      = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        got      = reg_rd_data;
    endtask
    task automatic shifts(input int exp, input int lexp);
        int lcnt;
        repeat (60) @(negedge sys_clk);
        cnt  = 0;
        lcnt = 0;
        repeat (16) begin
            @(negedge pixel_clock);
            cnt  += int'(shift_clock === 1'b1);
            lcnt += int'(load_clock === 1'b1);
        end
        chk("shift strobes", 8'(exp), 8'(cnt));
        chk("load strobes", 8'(lexp), 8'(lcnt));
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
    initial begin
        void'($urandom(32'hDC64));
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        rd(ADDR_CURSOR_RD_INDEX);
        chk("read index reset", 8'h00, got);
        rd(ADDR_GFX_FORMAT);
        chk("format reset", 8'h00, got);
        rd(5'h1F);
        chk("unmapped read", 8'h00, got);
        wr(ADDR_GFX_FORMAT, 8'hFF);
        rd(ADDR_GFX_FORMAT);
        chk("format reserved bit", 8'h7F, got);
        wr(ADDR_CURSOR_WR_INDEX, 8'h00);
        for (int i = 0; i < 12; i++) begin
            pal[i / 3][i % 3] = $urandom_range(255);
            wr(ADDR_CURSOR_DATA, 8'(pal[i / 3][i % 3]));
        end
        wr(ADDR_CURSOR_RD_INDEX, 8'h03);
        idx = 3;
        for (int i = 0; i < 9; i++) begin
            rd(ADDR_CURSOR_DATA);
            chk("palette byte", 8'(pal[idx][i % 3]), got);
            if (i % 3 == 2) begin
                idx = (idx + 1) % 4;
                rd(ADDR_CURSOR_RD_INDEX);
                chk("read index", 8'(idx), got);
            end
        end
        for (int g = 0; g < 2; g++) begin
            for (int d = 0; d < 4; d++) begin
                port_select_input = g[0];
                wr(ADDR_CURSOR_SETUP, {1'b0, d[1:0], 5'h00});
                repeat (6) @(negedge sys_clk);
                chk("wide active", 8'(d == 2 || (d == 1 && g == 1)),
                    8'(wide_port_active));
                chk("serial drive", 8'(d == 3), 8'(serial_port_drive));
            end
        end
        wr(ADDR_CURSOR_SETUP, 8'h40);
        for (int m = 0; m < 8; m++) begin
            tc = 1'($urandom_range(1));
            cf = m[0] & 1'($urandom_range(1));
            wr(ADDR_GFX_FORMAT, {1'b0, m[2:1], tc, cf, m[0], m[1],
                                 1'($urandom_range(1))});
            shifts(16 / ratio[m], 16 / ratio[m]);
            chk("bypass", 8'(tc), 8'(pixel_out.palette_bypass));
            if (m[2:1] == 2'b01)
                chk("rgb565", 8'(cf), 8'(pixel_out.rgb565));
        end
        wr(ADDR_GFX_FORMAT, 8'h70);
        wr(ADDR_CURSOR_SETUP, 8'h00);
        shifts(16, 2);
        chk("legacy bypass", 8'h00, 8'(pixel_out.palette_bypass));
        wr(ADDR_CURSOR_SETUP, 8'hC0);
        shifts(0, 2);
        wr(ADDR_ANALOG_SETUP, 8'h41);
        shifts(16, 16);
        chk("dac off", 8'h01, 8'(dac_disable));
        wr(ADDR_ANALOG_SETUP, 8'h01);
        shifts(0, 2);
        chk("dac on", 8'h00, 8'(dac_disable));
        summarize();
    end
endmodule
